// ---- adcsfi_pkg.sv ----
// Purpose: Shared constants and types for the serial frame interface of the converter.
// Assumes: One 250 MHz system clock; all link pins arrive asynchronously.
// Notes:   Frame layout is fixed: leading zeros, then the result MSB first.
package adcsfi_pkg;

	localparam int          RES_BITS    = 10;
	localparam int          LEAD_ZEROS  = 6;
	localparam int          FRAME_BITS  = LEAD_ZEROS + RES_BITS;
	localparam int          CNT_W       = 5;
	localparam int          FIFO_DEPTH  = 16;
	localparam int          CLK_MHZ     = 250;

	// Bit counter values, at counter width
	localparam logic [CNT_W-1:0] CNT_IDLE  = 5'h00;
	localparam logic [CNT_W-1:0] CNT_FIRST = 5'h01;
	localparam logic [CNT_W-1:0] CNT_LOAD  = 5'(LEAD_ZEROS - 1);
	localparam logic [CNT_W-1:0] CNT_ACQ   = 5'(LEAD_ZEROS);
	localparam logic [CNT_W-1:0] CNT_LAST  = 5'(FRAME_BITS);

	// Values after reset
	localparam logic        PIN_CS_RST    = 1'b1;
	localparam logic        PIN_LOW_RST   = 1'b0;
	localparam logic        OE_N_RST      = 1'b1;
	localparam logic        PDOWN_RST     = 1'b1;
	localparam logic        MODE_RST      = 1'b0;
	localparam logic [RES_BITS-1:0] SHREG_RST = 10'h000;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_LATCH = 3'b001,
		ST_WAIT  = 3'b010,
		ST_ARM   = 3'b011,
		ST_SHIFT = 3'b100,
		ST_DONE  = 3'b101
	} adcsfi_state_t;

endpackage : adcsfi_pkg

// ---- adcsfi_fifo.sv ----
// Purpose: Result buffer between the conversion source and the serial shifter.
// Assumes: DEPTH is a power of two; pointers wrap naturally.
// Notes:   Read data and in_ready come from registers; one extra word sits in the output stage.
`timescale 1ns/1ps
module adcsfi_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  in_ready,
	output logic                  out_valid,
	output logic      [WIDTH-1:0] out_data,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             push;
	logic             fill;
	logic             in_ready_q;
	logic             out_valid_q;
	logic [WIDTH-1:0] out_data_q;

	assign push      = in_valid && in_ready_q;
	assign fill      = (!out_valid_q || out_ready) && (cnt_q != '0);
	assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, fill};
	assign in_ready  = in_ready_q;
	assign out_valid = out_valid_q;
	assign out_data  = out_data_q;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_q       <= '0;
			rd_q       <= '0;
			cnt_q      <= '0;
			in_ready_q <= 1'b0;
		end else begin
			cnt_q      <= cnt_d;
			in_ready_q <= (cnt_d != (AW+1)'(DEPTH));
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (fill) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end

	// Output stage stalls while the shifter is not taking a word
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else if (fill) begin
			out_valid_q <= 1'b1;
			out_data_q  <= mem_q[rd_q];
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

endmodule : adcsfi_fifo

// ---- adcsfi_core.sv ----
// Purpose: Mode select, conversion sequencing and serial frame output of the converter.
// Assumes: cs_n, sclk and frame_sync are pins, oversampled by the 250 MHz clock.
// Notes:   sclk must stay well below a quarter of clk so every edge is seen.
`timescale 1ns/1ps
module adcsfi_core
	import adcsfi_pkg::*;
(
	input  wire logic                           clk,
	input  wire logic                           nrst,
	input  wire logic                           cs_n,
	input  wire logic                           sclk,
	input  wire logic                           frame_sync,
	output logic                                serial_out,
	output logic                                serial_out_oe_n,
	output logic                                power_down,
	output logic                                select_mode,
	output logic                                acquiring,
	input  wire logic [adcsfi_pkg::RES_BITS-1:0] result_data,
	input  wire logic                           result_valid,
	output logic                                result_ready
);
	import adcsfi_pkg::*;

	logic                rst_s1_q;
	logic                rst_n;
	logic                cs_s1_q;
	logic                cs_s2_q;
	logic                cs_s3_q;
	logic                sclk_s1_q;
	logic                sclk_s2_q;
	logic                sclk_s3_q;
	logic                fs_s1_q;
	logic                fs_s2_q;
	logic                sclk_rise;
	logic                sclk_fall;
	logic                cs_high;
	adcsfi_state_t       st_q;
	adcsfi_state_t       st_d;
	logic [CNT_W-1:0]    cnt_q;
	logic [CNT_W-1:0]    cnt_d;
	logic                fs_a_q;
	logic                mode_q;
	logic                dout_q;
	logic                oe_n_q;
	logic                pd_q;
	logic                acq_q;
	logic [RES_BITS-1:0] shreg_q;
	logic                adv;
	logic                pop;
	logic                word_valid;
	logic [RES_BITS-1:0] word_data;
	logic                chain;

	// Reset release through two flops; assertion stays asynchronous
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_q <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_n    <= rst_s1_q;
		end
	end

	// Pin synchronisers; sclk third stage for edge detection, cs third stage unused
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s1_q   <= PIN_CS_RST;
			cs_s2_q   <= PIN_CS_RST;
			cs_s3_q   <= PIN_CS_RST;
			sclk_s1_q <= PIN_LOW_RST;
			sclk_s2_q <= PIN_LOW_RST;
			sclk_s3_q <= PIN_LOW_RST;
			fs_s1_q   <= PIN_LOW_RST;
			fs_s2_q   <= PIN_LOW_RST;
		end else begin
			cs_s1_q   <= cs_n;
			cs_s2_q   <= cs_s1_q;
			cs_s3_q   <= cs_s2_q;
			sclk_s1_q <= sclk;
			sclk_s2_q <= sclk_s1_q;
			sclk_s3_q <= sclk_s2_q;
			fs_s1_q   <= frame_sync;
			fs_s2_q   <= fs_s1_q;
		end
	end

	assign sclk_rise = sclk_s2_q && !sclk_s3_q;
	assign sclk_fall = !sclk_s2_q && sclk_s3_q;
	assign cs_high   = cs_s2_q;

	// Shift step on a rising edge while the frame is still running
	assign adv = (st_q == ST_SHIFT) && !cs_high && sclk_rise && (cnt_q != CNT_LAST);
	assign pop = adv && (cnt_q == CNT_LOAD);
	// Last bit on the line; a frame start here chains the next conversion
	assign chain = (st_q == ST_SHIFT) && (cnt_q == CNT_LAST);

	always_comb begin
		st_d  = st_q;
		cnt_d = cnt_q;
		if (cs_high) begin
			// Early raise drops the frame with no partial state kept
			st_d  = ST_IDLE;
			cnt_d = CNT_IDLE;
		end else begin
			unique case (st_q)
				ST_IDLE: begin
					st_d = ST_LATCH;
				end
				ST_LATCH: begin
					// Both samples must be one, a glitch falls back to frame mode
					st_d = (fs_a_q && fs_s2_q) ? ST_DONE : ST_WAIT;
				end
				ST_WAIT: begin
					if (sclk_fall && fs_s2_q) begin
						st_d = ST_ARM;
					end
				end
				ST_ARM: begin
					if (sclk_fall && !fs_s2_q) begin
						st_d  = ST_SHIFT;
						cnt_d = CNT_FIRST;
					end
				end
				ST_SHIFT: begin
					if (sclk_fall && !mode_q && fs_s2_q) begin
						st_d  = ST_ARM;
						cnt_d = CNT_IDLE;
					end else if (sclk_fall && cnt_q == CNT_LAST) begin
						st_d = ST_DONE;
					end else if (adv) begin
						cnt_d = cnt_q + 5'h01;
					end
				end
				ST_DONE: begin
					if (mode_q) begin
						if (sclk_rise) begin
							st_d  = ST_SHIFT;
							cnt_d = CNT_FIRST;
						end
					end else if (sclk_fall && fs_s2_q) begin
						st_d  = ST_ARM;
						cnt_d = CNT_IDLE;
					end else if (sclk_rise) begin
						st_d = ST_WAIT;
					end
				end
				default: begin
					st_d  = ST_IDLE;
					cnt_d = CNT_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q  <= ST_IDLE;
			cnt_q <= CNT_IDLE;
		end else begin
			st_q  <= st_d;
			cnt_q <= cnt_d;
		end
	end

	// Mode latch: first sample at the select fall, second one cycle later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fs_a_q <= PIN_LOW_RST;
			mode_q <= MODE_RST;
		end else begin
			if (st_q == ST_IDLE) begin
				fs_a_q <= fs_s2_q;
			end
			if (st_q == ST_LATCH) begin
				mode_q <= fs_a_q && fs_s2_q;
			end
		end
	end

	// Serial data and result shifter
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dout_q  <= 1'b0;
			shreg_q <= SHREG_RST;
		end else if (st_d == ST_IDLE || (st_d == ST_ARM && !chain)) begin
			dout_q  <= 1'b0;
			shreg_q <= SHREG_RST;
		end else if (st_d == ST_SHIFT && st_q != ST_SHIFT) begin
			dout_q <= 1'b0;
		end else if (adv) begin
			if (cnt_q < CNT_ACQ) begin
				dout_q <= 1'b0;
			end else begin
				dout_q  <= shreg_q[RES_BITS-1];
				shreg_q <= {shreg_q[RES_BITS-2:0], 1'b0};
			end
			// Empty buffer yields a zero result rather than stalling the host clock
			if (pop) begin
				shreg_q <= word_valid ? word_data : SHREG_RST;
			end
		end
	end

	// Output enable, active low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			oe_n_q <= OE_N_RST;
		end else if (st_d == ST_IDLE) begin
			oe_n_q <= 1'b1;
		end else if (st_q == ST_LATCH || st_d == ST_ARM) begin
			oe_n_q <= 1'b0;
		end else if (st_q == ST_DONE && st_d == ST_WAIT) begin
			oe_n_q <= 1'b1;
		end
	end

	// Power state and acquisition window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_q  <= PDOWN_RST;
			acq_q <= 1'b0;
		end else begin
			pd_q  <= !(st_d == ST_ARM || st_d == ST_SHIFT);
			acq_q <= (st_d == ST_ARM) || (st_d == ST_SHIFT && cnt_d < CNT_ACQ);
		end
	end

	adcsfi_fifo #(
		.WIDTH (RES_BITS),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rst_n     (rst_n),
		.in_valid  (result_valid),
		.in_data   (result_data),
		.in_ready  (result_ready),
		.out_valid (word_valid),
		.out_data  (word_data),
		.out_ready (pop)
	);

	assign serial_out      = dout_q;
	assign serial_out_oe_n = oe_n_q;
	assign power_down      = pd_q;
	assign select_mode     = mode_q;
	assign acquiring       = acq_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	property p_mode_latch;
		(st_q == ST_LATCH) |=> (mode_q == $past(fs_a_q && fs_s2_q));
	endproperty
	a_mode_latch: assert property (p_mode_latch) else $error("mode latch wrong");

	property p_cs_off;
		cs_high |=> (oe_n_q && pd_q && st_q == ST_IDLE);
	endproperty
	a_cs_off: assert property (p_cs_off) else $error("select high not off");

	property p_wait_pd;
		(st_q == ST_WAIT) |-> (pd_q && !acq_q);
	endproperty
	a_wait_pd: assert property (p_wait_pd) else $error("awake while waiting");

	property p_fs_arm;
		(!cs_high && sclk_fall && fs_s2_q && !mode_q && st_q inside {ST_WAIT, ST_SHIFT})
			|=> (st_q == ST_ARM) ##0 (!pd_q && acq_q && !oe_n_q);
	endproperty
	a_fs_arm: assert property (p_fs_arm) else $error("frame_sync not armed");

	property p_first_zero;
		(st_q == ST_ARM && !cs_high && sclk_fall && !fs_s2_q)
			|=> (st_q == ST_SHIFT && cnt_q == CNT_FIRST && !dout_q && !oe_n_q);
	endproperty
	a_first_zero: assert property (p_first_zero) else $error("no first zero");

	property p_zeros;
		(st_q == ST_SHIFT && cnt_q <= CNT_ACQ) |-> (!dout_q && !oe_n_q);
	endproperty
	a_zeros: assert property (p_zeros) else $error("leading bit not zero");

	property p_acq_end;
		(st_q == ST_SHIFT && cnt_q == CNT_LOAD && adv) |=> (!acq_q && cnt_q == CNT_ACQ);
	endproperty
	a_acq_end: assert property (p_acq_end) else $error("acquire window wrong");

	property p_pd17;
		(st_q == ST_SHIFT && cnt_q == CNT_LAST && sclk_fall && !cs_high && !(fs_s2_q && !mode_q))
			|=> (st_q == ST_DONE && pd_q) ##1 pd_q;
	endproperty
	a_pd17: assert property (p_pd17) else $error("no power-down after LSB");

	property p_tri17;
		(st_q == ST_DONE && !mode_q && sclk_rise && !cs_high && !sclk_fall) |=> oe_n_q;
	endproperty
	a_tri17: assert property (p_tri17) else $error("not tri-stated");

	property p_sel_wake;
		(st_q == ST_DONE && mode_q && sclk_rise && !cs_high)
			|=> (st_q == ST_SHIFT && cnt_q == CNT_FIRST && !pd_q && acq_q);
	endproperty
	a_sel_wake: assert property (p_sel_wake) else $error("select mode no wake");

	property p_msb_first;
		(adv && cnt_q >= CNT_ACQ) |=> (dout_q == $past(shreg_q[RES_BITS-1]));
	endproperty
	a_msb_first: assert property (p_msb_first) else $error("result bit order");

	property p_chain;
		(chain && !cs_high && sclk_fall && fs_s2_q && !mode_q)
			|=> (st_q == ST_ARM && !pd_q && dout_q == $past(dout_q));
	endproperty
	a_chain: assert property (p_chain) else $error("chained frame lost LSB");

	property p_restart;
		(st_q == ST_SHIFT && !chain && !cs_high && sclk_fall && fs_s2_q && !mode_q)
			|=> (cnt_q == CNT_IDLE && shreg_q == SHREG_RST && !dout_q);
	endproperty
	a_restart: assert property (p_restart) else $error("restart kept old frame");

endmodule : adcsfi_core

// ---- adcsfi_host_model.sv ----
// Purpose: Host model driving chip-select, serial clock and frame sync, capturing serial_out.
// Assumes: Drives just after clk rises; each sclk half lasts HALF clk periods.
// Notes:   A released data line reads as the inverse of its last driven value.
`timescale 1ns/1ps
module adcsfi_host_model (
	input  wire logic clk,
	input  wire logic serial_out,
	input  wire logic serial_out_oe_n,
	output logic      cs_n,
	output logic      sclk,
	output logic      frame_sync
);
	localparam int HALF = 8;
	logic last_q;
	logic wire_v;

	initial begin
		cs_n       = 1'b1;
		sclk       = 1'b0;
		frame_sync = 1'b1;
		last_q     = 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!serial_out_oe_n) begin
			last_q <= serial_out;
		end
	end
	assign wire_v = serial_out_oe_n ? ~last_q : serial_out;

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_clk

	// Frame sync held steady across the select edge
	task automatic cs_low(input logic fsv);
		frame_sync = fsv;
		wait_clk(2);
		cs_n = 1'b0;
		wait_clk(HALF);
	endtask : cs_low

	task automatic cs_high();
		cs_n = 1'b1;
		wait_clk(HALF);
	endtask : cs_high

	// late: sample before the rise, for frames whose first bit leads the clock
	task automatic clocks(input int n, input bit late, output logic [15:0] bits);
		bits = 16'h0000;
		for (int i = 0; i < n; i++) begin
			wait_clk(HALF);
			if (late) begin
				bits = {bits[14:0], wire_v};
			end
			sclk = 1'b1;
			wait_clk(HALF);
			if (!late) begin
				bits = {bits[14:0], wire_v};
			end
			sclk = 1'b0;
		end
	endtask : clocks

	task automatic fs_start();
		logic [15:0] d;
		frame_sync = 1'b1;
		clocks(1, 1'b0, d);
		wait_clk(2);
		frame_sync = 1'b0;
		clocks(1, 1'b0, d);
	endtask : fs_start

	// Frame start raised inside bit 16; bits[1:0] are bits 15 and 16
	task automatic fs_chain(output logic [15:0] bits);
		bits = 16'h0000;
		wait_clk(HALF);
		bits[1] = wire_v;
		sclk = 1'b1;
		wait_clk(2);
		frame_sync = 1'b1;
		wait_clk(HALF - 2);
		sclk = 1'b0;
		wait_clk(2);
		frame_sync = 1'b0;
		wait_clk(HALF - 2);
		bits[0] = wire_v;
		sclk = 1'b1;
		wait_clk(HALF);
		sclk = 1'b0;
	endtask : fs_chain
endmodule : adcsfi_host_model

// ---- testbench.sv ----
// Purpose: Self-checking bench for the converter serial frame interface.
// Assumes: Host model supplies all pin traffic; bench feeds results into the buffer.
// Notes:   Expected frames are built from the pushed words, six zeros then the word.
`timescale 1ns/1ps
module testbench;
	import adcsfi_pkg::*;
	logic                clk;
	logic                nrst;
	logic                result_valid;
	logic [RES_BITS-1:0] result_data;
	logic                cs_n, sclk, frame_sync, serial_out, serial_out_oe_n;
	logic                power_down, select_mode, acquiring, result_ready;
	logic [15:0]         a, b;
	int                  err_count, comparisons;

	adcsfi_core dut_u (.clk(clk), .nrst(nrst), .cs_n(cs_n), .sclk(sclk),
		.frame_sync(frame_sync), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .power_down(power_down),
		.select_mode(select_mode), .acquiring(acquiring), .result_data(result_data),
		.result_valid(result_valid), .result_ready(result_ready));
	adcsfi_host_model host_u (.clk(clk), .serial_out(serial_out),
		.serial_out_oe_n(serial_out_oe_n), .cs_n(cs_n), .sclk(sclk), .frame_sync(frame_sync));

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_clk

	task automatic finish_test();
		$display("counts: %0d comparisons, %0d mismatches", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : finish_test

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic push(input logic [RES_BITS-1:0] d);
		int i;
		result_data  = d;
		result_valid = 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (result_ready === 1'b1) break;
		end
		#1;
		result_valid = 1'b0;
		if (i == 50) begin
			err_count++;
			finish_test();
		end
		wait_clk(1);
	endtask : push

	task automatic t_reset();
		wait_clk(10);
		check(serial_out_oe_n, 16'h1);
		check(power_down, 16'h1);
		check({select_mode, acquiring, result_ready}, 16'h0);
		wait_clk(10);
		nrst = 1'b1;
		wait_clk(6);
		$display("test reset done");
	endtask : t_reset

	task automatic t_select();
		push(10'h2a5);
		host_u.cs_low(1'b1);
		check(select_mode, 16'h1);
		check(serial_out_oe_n, 16'h0);
		check(power_down, 16'h1);
		host_u.clocks(16, 1'b0, a);
		check(a, 16'h02a5);
		wait_clk(6);
		check(power_down, 16'h1);
		push(10'h15a);
		host_u.clocks(8, 1'b0, a);
		wait_clk(100);
		host_u.clocks(8, 1'b0, b);
		check({a[7:0], b[7:0]}, 16'h015a);
		host_u.cs_high();
		check({serial_out_oe_n, power_down}, 16'h3);
		$display("test select done");
	endtask : t_select

	task automatic t_trunc();
		push(10'h3ff);
		host_u.cs_low(1'b1);
		host_u.clocks(12, 1'b0, a);
		host_u.cs_high();
		check(a, 16'h003f);
		push(10'h001);
		host_u.cs_low(1'b1);
		host_u.clocks(16, 1'b0, a);
		host_u.cs_high();
		check(a, 16'h0001);
		$display("test truncate done");
	endtask : t_trunc

	task automatic t_frame();
		push(10'h1c3);
		push(10'h2f0);
		push(10'h2d2);
		push(10'h0b4);
		host_u.cs_low(1'b0);
		check(select_mode, 16'h0);
		check({serial_out_oe_n, power_down}, 16'h1);
		host_u.fs_start();
		check({power_down, acquiring}, 16'h1);
		host_u.clocks(15, 1'b1, a);
		wait_clk(6);
		check({serial_out_oe_n, power_down}, 16'h1);
		host_u.clocks(1, 1'b1, b);
		check({a[14:0], b[0]}, 16'h01c3);
		check(serial_out_oe_n, 16'h1);
		host_u.fs_start();
		check({serial_out_oe_n, power_down}, 16'h0);
		host_u.clocks(8, 1'b1, a);
		check(a, 16'h0002);
		host_u.fs_start();
		check(acquiring, 16'h1);
		host_u.clocks(14, 1'b1, a);
		host_u.fs_chain(b);
		check({a[13:0], b[1:0]}, 16'h02d2);
		check(power_down, 16'h0);
		host_u.clocks(16, 1'b1, a);
		check(a, 16'h00b4);
		host_u.cs_high();
		check(serial_out_oe_n, 16'h1);
		$display("test frame done");
	endtask : t_frame

	// Host stays deselected while the buffer fills
	task automatic t_fifo();
		int n;
		n = 0;
		result_data  = '0;
		result_valid = 1'b1;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			if (result_ready === 1'b1) n++;
			#1;
			result_data = RES_BITS'(n);
		end
		result_valid = 1'b0;
		check(16'(n), 16'(FIFO_DEPTH + 1));
		host_u.cs_low(1'b1);
		for (int i = 0; i <= FIFO_DEPTH; i++) begin
			host_u.clocks(16, 1'b0, a);
			check(a, 16'(i));
		end
		host_u.clocks(16, 1'b0, a);
		check(a, 16'h0000);
		host_u.cs_high();
		$display("test fifo done");
	endtask : t_fifo

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	initial begin
		nrst         = 1'b0;
		result_valid = 1'b0;
		result_data  = '0;
		err_count    = 0;
		comparisons  = 0;
		t_reset();
		t_select();
		t_trunc();
		t_frame();
		t_fifo();
		finish_test();
	end
endmodule : testbench
